// ===== verilog/grf_pkg.sv
// constants and types for the graphics port read flow control pair
// assumes one common clock shared by both ends
package grf_pkg;
   typedef enum logic [1:0] {
      GRF_MODE_1X = 2'h0,
      GRF_MODE_2X = 2'h1,
      GRF_MODE_4X = 2'h2
   } grf_mode_t;
   typedef enum logic [2:0] {
      GRF_ST_LOW_PRIORITY_READ = 3'h0,
      GRF_ST_HIGH_PRIORITY_READ = 3'h1,
      GRF_ST_LP_WRITE = 3'h2,
      GRF_ST_HP_WRITE = 3'h3,
      GRF_ST_REQ = 3'h7
   } grf_status_t;
   localparam int GRF_BLOCK_CLKS = 4;
   localparam int GRF_TP_OFFSET = 2;
   localparam int GRF_BYTES_1X_CLK = 4;
   localparam int GRF_BLOCK_1X = 16;
   localparam int GRF_BLOCK_2X = 32;
   localparam int GRF_BLOCK_4X = 64;
   localparam int GRF_SHORT_LEN = 8;
   localparam int GRF_PAIR_LEN_4X = 16;
endpackage : grf_pkg

// ===== verilog/grf_if.sv
// link between graphics master and corelogic (target plus arbiter)
// active low bus strobes are plain levels; no tri-state modelled
interface grf_if;
   logic gnt_n;
   grf_pkg::grf_status_t grant_status_code;
   logic trdy_n;
   logic irdy_n;
   logic read_buffer_full_n;
   logic [31:0] ad;
   modport master (
      input gnt_n, grant_status_code, trdy_n, ad,
      output irdy_n, read_buffer_full_n
   );
   modport corelogic (
      output gnt_n, grant_status_code, trdy_n, ad,
      input irdy_n, read_buffer_full_n
   );
endinterface : grf_if

// ===== verilog/grf_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes single clock, async active-high reset
module grf_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // write side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // occupancy
   output logic [$clog2(DEPTH+1)-1:0] free_words
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;
   assign in_ready = (count_reg != CW'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign free_words = CW'(DEPTH) - count_reg;
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
      end
   end
endmodule : grf_fifo

// ===== verilog/grf_master.sv
// graphics master end: read buffer, read_buffer_full_n and irdy throttling
// assumes corelogic keeps its arbiter duties; one clock for both ends
module grf_master #(
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   grf_if.master link,
   // configuration
   input wire logic [1:0] mode,
   input wire logic [7:0] next_len_a,
   input wire logic [7:0] next_len_b,
   // consumer
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [31:0] rd_data
);
   localparam int CW = $clog2(DEPTH+1);
   localparam int CW1 = CW + 1;
   logic [CW-1:0] free_words;
   logic fifo_in_ready;
   logic in_data_reg;
   logic wait_reg;
   logic resume_reg;
   logic tp_ok_reg;
   logic [3:0] phase_reg;
   logic [5:0] cnt_reg;
   logic [9:0] need_bytes;
   logic [9:0] free_bytes;
   logic [9:0] cap;
   logic [CW:0] room_sum;
   logic room;
   logic start;
   logic both_rdy;
   logic full_n_reg;
   logic irdy_n_reg;
   logic data_take;
   // a return starts on trdy when no return or wait is open
   assign start = !in_data_reg && !wait_reg && !resume_reg && !link.trdy_n;
   assign both_rdy = !link.trdy_n && !link.irdy_n;
   assign data_take = in_data_reg || start;
   // room when free words, plus one block if the consumer is draining, reach DEPTH
   assign room_sum = {1'b0, free_words} + (rd_ready ? CW1'(grf_pkg::GRF_BLOCK_CLKS) : '0);
   assign room = (room_sum >= CW1'(DEPTH));
   grf_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(data_take),
      .in_ready(fifo_in_ready),
      .in_data(link.ad),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data),
      .free_words(free_words)
   );
   // high and low priority returns share this tracking
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_data_reg <= 1'b0;
         wait_reg <= 1'b0;
         resume_reg <= 1'b0;
         tp_ok_reg <= 1'b0;
         phase_reg <= '0;
         cnt_reg <= '0;
      end else if (start) begin
         in_data_reg <= (next_len_a[7:2] > 6'h01);
         cnt_reg <= next_len_a[7:2] - 6'h01;
         phase_reg <= 4'h1;
      end else if (in_data_reg) begin
         cnt_reg <= cnt_reg - 6'h01;
         phase_reg <= (phase_reg == 4'(grf_pkg::GRF_BLOCK_CLKS - 1)) ? '0 : phase_reg + 4'h1;
         if (phase_reg == 4'(grf_pkg::GRF_TP_OFFSET)) begin
            tp_ok_reg <= both_rdy;
         end
         if (cnt_reg == 6'h01) begin
            in_data_reg <= 1'b0;
         end else if (phase_reg == 4'(grf_pkg::GRF_BLOCK_CLKS - 1) && !tp_ok_reg) begin
            in_data_reg <= 1'b0;
            wait_reg <= 1'b1;
         end
      end else if (wait_reg) begin
         if (both_rdy) begin
            wait_reg <= 1'b0;
            resume_reg <= 1'b1;
         end
      end else if (resume_reg) begin
         resume_reg <= 1'b0;
         in_data_reg <= 1'b1;
         phase_reg <= '0;
      end
   end
   always_comb begin
      free_bytes = 10'(free_words) * 10'h004;
      need_bytes = 10'(next_len_a);
      cap = 10'(grf_pkg::GRF_BLOCK_1X);
      unique case (mode)
         2'(grf_pkg::GRF_MODE_2X): begin
            cap = 10'(grf_pkg::GRF_BLOCK_2X);
            if (next_len_a == 8'(grf_pkg::GRF_SHORT_LEN)) begin
               need_bytes = 10'(next_len_a) + ((10'(next_len_b) > cap) ? cap : 10'(next_len_b));
            end else begin
               need_bytes = (10'(next_len_a) > cap) ? cap : 10'(next_len_a);
            end
         end
         2'(grf_pkg::GRF_MODE_4X): begin
            cap = 10'(grf_pkg::GRF_BLOCK_4X);
            if (next_len_a == 8'(grf_pkg::GRF_SHORT_LEN) ||
                next_len_a == 8'(grf_pkg::GRF_PAIR_LEN_4X)) begin
               need_bytes = 10'(next_len_a) + ((10'(next_len_b) > cap) ? cap : 10'(next_len_b));
            end else begin
               need_bytes = (10'(next_len_a) > cap) ? cap : 10'(next_len_a);
            end
         end
         default: begin
            need_bytes = (10'(next_len_a) > cap) ? 10'(next_len_a) : cap;
         end
      endcase
   end
   // full when free bytes fall below need_bytes, which 1X mode raises to at least 16; never keyed to high priority
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         full_n_reg <= 1'b0;
      end else begin
         full_n_reg <= (free_bytes >= need_bytes);
      end
   end
   // throttle at block end when the buffer cannot take a block
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irdy_n_reg <= 1'b1;
      end else if (start || (in_data_reg && phase_reg == '0)) begin
         irdy_n_reg <= !room;
      end else if (wait_reg && !both_rdy) begin
         irdy_n_reg <= !room;
      end else if (in_data_reg && phase_reg == 4'(grf_pkg::GRF_TP_OFFSET - 1)) begin
         irdy_n_reg <= irdy_n_reg;
      end else begin
         irdy_n_reg <= 1'b1;
      end
   end
   assign link.read_buffer_full_n = full_n_reg;
   assign link.irdy_n = irdy_n_reg;
endmodule : grf_master

// ===== verilog/grf_corelogic.sv
// corelogic end: arbiter grants and read data returns
// assumes master keeps its buffering; sampling on rising clk
module grf_corelogic (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   grf_if.corelogic link,
   // request side
   input wire logic req_valid,
   input wire logic req_hp,
   input wire logic [7:0] req_len,
   output logic req_ready,
   input wire logic [31:0] src_data
);
   typedef enum logic [3:0] {
      GRF_S_IDLE = 4'b0001,
      GRF_S_DATA = 4'b0010,
      GRF_S_WAIT = 4'b0100,
      GRF_S_GAP = 4'b1000
   } grf_cstate_t;
   logic thr_reg;
   grf_cstate_t state_reg;
   logic [7:0] left_reg;
   logic [1:0] ph_reg;
   logic gnt_n_reg;
   logic trdy_n_reg;
   logic [2:0] st_reg;
   logic [31:0] ad_reg;
   logic full_seen_reg;
   logic ok;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         full_seen_reg <= 1'b1;
      end else begin
         full_seen_reg <= !link.read_buffer_full_n;
      end
   end
   assign ok = req_valid && (req_hp || !full_seen_reg);
   assign req_ready = (state_reg == GRF_S_IDLE) && ok;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= GRF_S_IDLE;
         thr_reg <= 1'b0;
         left_reg <= '0;
         ph_reg <= '0;
         gnt_n_reg <= 1'b1;
         trdy_n_reg <= 1'b1;
         st_reg <= 3'h7;
         ad_reg <= '0;
      end else begin
         gnt_n_reg <= 1'b1;
         trdy_n_reg <= 1'b1;
         ad_reg <= src_data;
         unique case (state_reg)
            GRF_S_IDLE: begin
               if (ok) begin
                  gnt_n_reg <= 1'b0;
                  st_reg <= req_hp ? 3'(grf_pkg::GRF_ST_HIGH_PRIORITY_READ) : 3'(grf_pkg::GRF_ST_LOW_PRIORITY_READ);
                  trdy_n_reg <= 1'b0;
                  left_reg <= (req_len > 8'h04) ? req_len - 8'h04 : 8'h00;
                  ph_reg <= 2'h1;
                  state_reg <= (req_len > 8'h04) ? GRF_S_DATA : GRF_S_IDLE;
               end
            end
            GRF_S_DATA: begin
               ph_reg <= ph_reg + 2'h1;
               left_reg <= (left_reg > 8'h04) ? left_reg - 8'h04 : 8'h00;
               // throttle point only when data lies beyond this block
               if (ph_reg == 2'(grf_pkg::GRF_TP_OFFSET) && left_reg > 8'h0c) begin
                  if (!link.irdy_n) begin
                     trdy_n_reg <= 1'b0;
                  end else begin
                     thr_reg <= 1'b1;
                  end
               end
               if (left_reg <= 8'h04) begin
                  state_reg <= GRF_S_IDLE;
                  thr_reg <= 1'b0;
               end else if (ph_reg == 2'h0 && thr_reg) begin
                  state_reg <= GRF_S_WAIT;
                  thr_reg <= 1'b0;
               end
            end
            GRF_S_WAIT: begin
               if (!link.irdy_n) begin
                  trdy_n_reg <= 1'b0;
                  ph_reg <= 2'h2;
                  state_reg <= GRF_S_GAP;
               end
            end
            GRF_S_GAP: begin
               // data resumes two clocks after both ready
               ph_reg <= ph_reg + 2'h1;
               if (ph_reg == 2'h3) begin
                  ph_reg <= 2'h1;
                  state_reg <= GRF_S_DATA;
               end
            end
            default: begin
               state_reg <= GRF_S_IDLE;
            end
         endcase
      end
   end
   assign link.gnt_n = gnt_n_reg;
   assign link.grant_status_code = grf_pkg::grf_status_t'(st_reg);
   assign link.trdy_n = trdy_n_reg;
   assign link.ad = ad_reg;
endmodule : grf_corelogic

// ===== testbench/grf_link_monitor.sv
// assertions on the link between the two ends
// assumes one rising clk and async active-high sys_rst
module grf_link_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   input wire logic gnt_n,
   input wire grf_pkg::grf_status_t grant_status_code,
   input wire logic trdy_n,
   input wire logic irdy_n,
   input wire logic read_buffer_full_n,
   input wire logic [31:0] ad
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_full_blocks_lp: assert property ((!read_buffer_full_n)[*3] |->
      !(!gnt_n && grant_status_code == grf_pkg::GRF_ST_LOW_PRIORITY_READ)) else $error("lp grant while full");
   a_grant_has_trdy: assert property (!gnt_n |-> !trdy_n) else $error("grant without trdy");
   a_grant_single: assert property (!gnt_n |=> gnt_n) else $error("grant too long");
   a_grant_is_read: assert property (!gnt_n |->
      grant_status_code inside {grf_pkg::GRF_ST_LOW_PRIORITY_READ, grf_pkg::GRF_ST_HIGH_PRIORITY_READ})
      else $error("grant code not a read");
   a_trdy_single: assert property (!trdy_n |=> trdy_n) else $error("trdy too long");
   a_tp_both_ready: assert property (!trdy_n && gnt_n |-> !irdy_n) else $error("resume no irdy");
   a_tp_spacing: assert property (!trdy_n && gnt_n |=> trdy_n[*3]) else $error("tp too close");
   a_full_clears: assert property (!read_buffer_full_n |-> ##[0:200] read_buffer_full_n)
      else $error("full held too long");
endmodule : grf_link_monitor

// ===== testbench/tb_graphics_port_read_flow_control.sv
// self-checking bench for the master and corelogic pair
// assumes both ends share clk; an 8 word fifo sits in the master
module tb_graphics_port_read_flow_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, req_valid, req_hp, req_ready, rd_valid, rd_ready;
   logic [1:0] mode;
   logic [7:0] len_a, len_b, req_len;
   logic [31:0] src_data, rd_data, last_word;
   int err_total = 0, checks = 0, got = 0, b;
   grf_if link ();
   grf_master i_grf_master (.clk(clk), .sys_rst(sys_rst), .link(link), .mode(mode),
      .next_len_a(len_a), .next_len_b(len_b), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data));
   grf_corelogic i_grf_corelogic (.clk(clk), .sys_rst(sys_rst), .link(link),
      .req_valid(req_valid), .req_hp(req_hp), .req_len(req_len), .req_ready(req_ready),
      .src_data(src_data));
   grf_link_monitor i_grf_link_monitor (.clk(clk), .sys_rst(sys_rst), .gnt_n(link.gnt_n),
      .grant_status_code(link.grant_status_code), .trdy_n(link.trdy_n), .irdy_n(link.irdy_n),
      .read_buffer_full_n(link.read_buffer_full_n), .ad(link.ad));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rd_valid && rd_ready) begin
         got <= got + 1;
         last_word <= rd_data;
      end
   end
   task automatic tally_and_finish();
      if (err_total == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   // holds the request until taken; caller lowers req_valid
   task automatic send(input logic hp, input logic [7:0] len, input logic [31:0] d);
      int n;
      req_valid = 1'b1;
      req_hp = hp;
      req_len = len;
      src_data = d;
      n = 0;
      #1;
      while (!req_ready && n < 300) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      if (n >= 300) err_total++;
   endtask : send
   task automatic drain(input int want, input logic [31:0] w);
      int n;
      n = 0;
      rd_ready = 1'b1;
      while (got - b < want && n < 600) begin
         @(negedge clk);
         n++;
      end
      repeat (6) @(negedge clk);
      check(32'(got - b), 32'(want));
      check(last_word, w);
   endtask : drain
   task automatic t_pair();
      mode = grf_pkg::GRF_MODE_2X;
      b = got;
      send(1'b0, 8'h08, 32'h0000_00a1);
      send(1'b0, 8'h08, 32'h0000_00a2);
      req_valid = 1'b0;
      drain(4, 32'h0000_00a2);
   endtask : t_pair
   task automatic t_modes();
      len_a = 8'h20;
      len_b = 8'h20;
      for (int m = 0; m < 3; m++) begin
         mode = 2'(m);
         b = got;
         send(1'b0, 8'h20, 32'h0000_00b0 + 32'(m));
         req_valid = 1'b0;
         drain(8, 32'h0000_00b0 + 32'(m));
      end
   endtask : t_modes
   task automatic t_fill();
      rd_ready = 1'b0;
      len_a = 8'h08;
      len_b = 8'h08;
      b = got;
      for (int i = 0; i < 3; i++) send(1'b0, 8'h08, 32'h0000_00c0);
      req_valid = 1'b0;
      repeat (6) @(negedge clk);
      check(32'(link.read_buffer_full_n), 32'h0);
      send(1'b1, 8'h08, 32'h0000_00c1);
      req_valid = 1'b0;
      @(negedge clk);
      req_hp = 1'b0;
      req_valid = 1'b1;
      repeat (6) begin
         @(negedge clk);
         check(32'(req_ready), 32'h0);
      end
      @(negedge clk);
      rd_ready = 1'b1;
      send(1'b0, 8'h08, 32'h0000_00c2);
      req_valid = 1'b0;
      drain(10, 32'h0000_00c2);
   endtask : t_fill
   task automatic t_throttle();
      rd_ready = 1'b0;
      len_a = 8'h40;
      b = got;
      send(1'b1, 8'h40, 32'h0000_00d1);
      req_valid = 1'b0;
      repeat (30) @(negedge clk);
      drain(16, 32'h0000_00d1);
   endtask : t_throttle
   initial begin
      #200us;
      err_total++;
      tally_and_finish();
   end
   initial begin
      sys_rst = 1'b1;
      {req_valid, req_hp, rd_ready} = 3'h0;
      {mode, len_a, len_b, req_len, src_data} = '0;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      len_a = 8'h08;
      len_b = 8'h08;
      repeat (2) @(negedge clk);
      t_pair();
      t_modes();
      t_fill();
      t_throttle();
      tally_and_finish();
   end
endmodule : tb_graphics_port_read_flow_control
